// ---- bench/sit_host_model.sv ----
// Purpose: Host side of the register port, reading status and flags.
// Assumes: Strobes change 1 ns after the rising edge of core_clk.
// Notes:   Released address and data show inverted values, never stale.
`timescale 1ns/100ps
module sit_host_model
  import sit_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic [RW-1:0] regRdata,
  output logic [7:0]         regAddr,
  output logic               regRd,
  output logic               regWr,
  output logic [RW-1:0]      regWdata
);
  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  initial begin
    regAddr  = 8'h00;
    regRd    = 1'b0;
    regWr    = 1'b0;
    regWdata = 8'h00;
  end

  task automatic rd(input logic [7:0] a, output logic [RW-1:0] d);
    @(posedge core_clk);
    #1;
    regAddr = a;
    regRd   = 1'b1;
    @(posedge core_clk);
    #1;
    regRd   = 1'b0;
    regAddr = ~a;
    d       = regRdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [RW-1:0] w);
    @(posedge core_clk);
    #1;
    regAddr  = a;
    regWdata = w;
    regWr    = 1'b1;
    @(posedge core_clk);
    #1;
    regWr    = 1'b0;
    regAddr  = ~a;
    regWdata = ~w;
  endtask

  // Source first, then only the groups it flags
  task automatic service(output logic [RW-1:0] s, t, h);
    t = 8'h00;
    h = 8'h00;
    rd(ADDR_SRC, s);
    if (s[SRC_TOP_BIT] === 1'b1) rd(ADDR_INT_TOP, t);
    if (s[SRC_THM_BIT] === 1'b1) rd(ADDR_INT_THM, h);
  endtask
endmodule // sit_host_model

// ---- bench/sit_status_interrupt_thermal_ctrl_tb.sv ----
// Purpose: Self-checking bench for the housekeeping interrupt block.
// Assumes: Pin levels settle within six cycles through the syncs.
// Notes:   Interrupt line is open drain with a pull-up modelled here.
`timescale 1ns/100ps
module sit_status_interrupt_thermal_ctrl_tb
  import sit_pkg::*;
;
  logic               core_clk = 1'b0;
  logic               arst_n   = 1'b0;
  sit_pins_t          pins     = '0;
  sit_sel_t [NCH-1:0] sel;
  logic [7:0]         regAddr;
  logic               regRd;
  logic               regWr;
  logic [RW-1:0]      regWdata;
  logic [RW-1:0]      regRdata;
  logic [RW-1:0]      d;
  logic [RW-1:0]      s;
  logic [RW-1:0]      t;
  logic [RW-1:0]      h;
  logic               irqNOut;
  logic               irqNOe;
  logic               monOn;
  logic               shut;
  logic [NCH-1:0]     buckOn;
  wire                irqLine = irqNOe ? irqNOut : 1'b1;
  int                 miscompares = 0;
  int                 compares    = 0;
  logic [7:0] tA [11] = '{ADDR_SRC, ADDR_INT_TOP, ADDR_INT_THM,
    ADDR_MSK_TOP, ADDR_MSK_THM, ADDR_CFG, ADDR_VOUT0,
    ADDR_VOUT0 + 8'h01, ADDR_RF0, ADDR_RF0 + 8'h01, 8'h20};
  logic [7:0] tE [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00,
    8'h3C, 8'hA5, 8'h09, 8'h03, 8'h00};

  always #12.5 core_clk = ~core_clk;

  sit_status_interrupt_thermal_ctrl dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .pinsRaw(pins),
    .selectionResistorDecode(sel), .regAddr(regAddr), .regRd(regRd),
    .regWr(regWr), .regWdata(regWdata), .regRdata(regRdata),
    .interruptRequestNOut(irqNOut), .interruptRequestNOe(irqNOe),
    .buckOn(buckOn), .thermalMonitorActive(monOn),
    .thermalShutdown(shut));

  sit_host_model host_u (
    .core_clk(core_clk), .regRdata(regRdata), .regAddr(regAddr),
    .regRd(regRd), .regWr(regWr), .regWdata(regWdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk8(input logic [7:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk1(input logic g, e, input string m);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Bounded wait; a hang ends the run as a failure
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (irqLine !== lvl && n < 20) begin
      tick(1);
      n++;
    end
    chk1(irqLine, lvl, "interrupt pin");
    if (irqLine !== lvl) end_of_test();
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    sel[0] = '{8'h3C, 2'h1, 2'h2};
    sel[1] = '{8'hA5, 2'h3, 2'h0};
    pins.supplyAbovePor  = 1'b1;
    pins.serialEnablePin = 1'b1;
    repeat (16) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    tick(4);
    host_u.wr(8'h20, 8'hFF);
    foreach (tA[i]) begin
      host_u.rd(tA[i], d);
      chk8(d, tE[i], "reset table");
    end
    chk1(irqLine, 1'b1, "pin idle");
    chk1(monOn, 1'b0, "monitor idle");
    host_u.wr(ADDR_CFG, 8'h01);
    tick(6);
    chk1(monOn, 1'b1, "forced monitor");
    pins.therm.above105 = 1'b1;
    pins.therm.above120 = 1'b1;
    tick(6);
    chk1(irqLine, 1'b1, "masked flag");
    host_u.rd(ADDR_SRC, d);
    chk8(d, 8'h02, "source thermal");
    host_u.rd(ADDR_INT_THM, d);
    chk8(d, 8'h01, "warn low");
    host_u.rd(ADDR_SRC, d);
    chk8(d, 8'h00, "source cleared");
    tick(6);
    host_u.rd(ADDR_INT_THM, d);
    chk8(d, 8'h00, "no refire");
    // Hysteresis holds the monitor after the force bit drops
    host_u.wr(ADDR_CFG, 8'h00);
    tick(6);
    chk1(monOn, 1'b1, "hold at 120");
    pins.therm.above120 = 1'b0;
    tick(6);
    chk1(monOn, 1'b1, "hold to 105");
    host_u.rd(ADDR_STAT, d);
    chk8(d, 8'h09, "status hold");
    pins.therm.above105 = 1'b0;
    tick(6);
    chk1(monOn, 1'b0, "release");
    host_u.wr(ADDR_CFG, 8'h01);
    host_u.wr(ADDR_MSK_THM, 8'h00);
    pins.therm.above105 = 1'b1;
    pins.therm.above120 = 1'b1;
    pins.therm.above140 = 1'b1;
    wait_pin(1'b0);
    host_u.wr(ADDR_MSK_THM, 8'h07);
    wait_pin(1'b1);
    host_u.wr(ADDR_MSK_THM, 8'h00);
    wait_pin(1'b0);
    pins.undervoltage = 1'b1;
    tick(6);
    host_u.rd(ADDR_SRC, d);
    chk8(d, 8'h03, "both groups");
    host_u.rd(ADDR_INT_TOP, d);
    chk8(d, 8'h01, "undervoltage flag");
    tick(2);
    chk1(irqLine, 1'b0, "still held");
    host_u.rd(ADDR_INT_THM, d);
    chk8(d, 8'h03, "both warnings");
    wait_pin(1'b1);
    pins.undervoltage = 1'b0;
    pins.therm = '0;
    host_u.wr(ADDR_CFG, 8'h00);
    pins.outputEnablePin = 2'b11;
    tick(6);
    chk1(monOn, 1'b1, "outputs on");
    chk8({6'h00, buckOn}, 8'h03, "bucks on");
    pins.therm.aboveShutdownThreshold = 1'b1;
    tick(5);
    chk1(shut, 1'b1, "shutdown");
    chk8({6'h00, buckOn}, 8'h00, "all off");
    wait_pin(1'b0);
    pins.therm.aboveShutdownThreshold = 1'b0;
    tick(4);
    host_u.service(s, t, h);
    chk8(s, 8'h02, "service source");
    chk8(h, 8'h04, "shutdown flag");
    wait_pin(1'b1);
    pins.outputEnablePin = 2'b00;
    sel[0] = '{8'h5A, 2'h2, 2'h1};
    tick(4);
    host_u.rd(ADDR_VOUT0, d);
    chk8(d, 8'h3C, "latched target");
    // Pass 0 drops the enables, pass 1 drops the supply
    for (int i = 0; i < 2; i++) begin
      host_u.wr(ADDR_MSK_TOP, 8'h01);
      host_u.wr(ADDR_CFG, 8'h01);
      pins.serialEnablePin = (i != 0);
      pins.supplyAbovePor  = (i == 0);
      tick(4);
      pins.serialEnablePin = 1'b1;
      pins.supplyAbovePor  = 1'b1;
      tick(4);
      host_u.rd(ADDR_CFG, d);
      chk8(d, 8'h00, "cfg default");
      host_u.rd(ADDR_MSK_TOP, d);
      chk8(d, 8'h00, "top mask");
      host_u.rd(ADDR_MSK_THM, d);
      chk8(d, 8'h07, "thermal mask");
      if (i == 0) begin
        host_u.rd(ADDR_VOUT0, d);
        chk8(d, 8'h5A, "new target");
        host_u.rd(ADDR_RF0, d);
        chk8(d, 8'h06, "new range freq");
      end
    end
    end_of_test();
  end
endmodule // sit_status_interrupt_thermal_ctrl_tb

// ---- rtl/sit_pkg.sv ----
// Purpose: Shared constants and types for the status, interrupt and
//          thermal housekeeping block.
// Assumes: Registers are 8 bits wide behind the serial interface engine.
// Notes:   Offsets are register addresses on the internal register port.
package sit_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 2;
  localparam int RW  = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SRC     = 8'h00;
  localparam logic [7:0] ADDR_INT_TOP = 8'h01;
  localparam logic [7:0] ADDR_INT_THM = 8'h02;
  localparam logic [7:0] ADDR_MSK_TOP = 8'h03;
  localparam logic [7:0] ADDR_MSK_THM = 8'h04;
  localparam logic [7:0] ADDR_CFG     = 8'h05;
  localparam logic [7:0] ADDR_STAT    = 8'h06;
  localparam logic [7:0] ADDR_VOUT0   = 8'h07;
  localparam logic [7:0] ADDR_RF0     = 8'h09;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SRC_TOP_BIT   = 0;
  localparam int SRC_THM_BIT   = 1;
  localparam int UNDERVOLTAGE_LOCKOUT_INTERRUPT_BIT = 0;
  localparam int THM_W120_BIT  = 0;
  localparam int THM_W140_BIT  = 1;
  localparam int THM_SHUT_BIT  = 2;
  localparam int THM_BITS      = 3;
  localparam int FORCE_THERMAL_MONITOR_ENABLE_BIT = 0;
  localparam int CFG_BUCK_LSB  = 1;
  localparam int STAT_MON_BIT  = 3;
  localparam int RF_RANGE_LSB  = 0;
  localparam int RF_FREQ_LSB   = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MSK_TOP_RST = 8'h00;
  localparam logic [7:0] MSK_THM_RST = 8'h07;
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam logic [7:0] VOUT_RST    = 8'h00;
  localparam logic [1:0] FIELD2_RST  = 2'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aboveShutdownThreshold;
    logic above140;
    logic above120;
    logic above105;
  } sit_therm_t;

  typedef struct packed {
    logic [7:0] outputVoltageTarget;
    logic [1:0] outputVoltageRange;
    logic [1:0] switchingFrequencySelect;
  } sit_sel_t;

  typedef struct packed {
    logic           supplyAbovePor;
    logic           undervoltage;
    logic           serialEnablePin;
    logic [NCH-1:0] outputEnablePin;
    sit_therm_t     therm;
  } sit_pins_t;

  localparam int PIN_W = $bits(sit_pins_t);
endpackage

// ---- rtl/sit_status_interrupt_thermal_ctrl.sv ----
// Purpose: Thermal monitor, clear-on-read interrupts, register resets.
// Assumes: Serial engine gives one-cycle read/write strobes on core_clk.
// Notes:   Comparator and pin levels are asynchronous and synchronised.
`timescale 1ns/100ps
module sit_status_interrupt_thermal_ctrl
  import sit_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire sit_pins_t            pinsRaw,
  input  wire sit_sel_t [NCH-1:0]   selectionResistorDecode,
  input  wire logic [7:0]           regAddr,
  input  wire logic                 regRd,
  input  wire logic                 regWr,
  input  wire logic [RW-1:0]        regWdata,
  output logic [RW-1:0]             regRdata,
  output logic                      interruptRequestNOut,
  output logic                      interruptRequestNOe,
  output logic [NCH-1:0]            buckOn,
  output logic                      thermalMonitorActive,
  output logic                      thermalShutdown
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] syncA;
  logic [PIN_W-1:0] syncB;
  sit_pins_t        pins;

  for (genvar b = 0; b < PIN_W; b++) begin : g_sync
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        syncA[b] <= 1'b0;
        syncB[b] <= 1'b0;
      end else begin
        syncA[b] <= pinsRaw[b];
        syncB[b] <= syncA[b];
      end
    end
  end
  assign pins = sit_pins_t'(syncB);

  // ----------------------------------------------------------------
  // Shutdown and default latch
  // ----------------------------------------------------------------
  logic anyEnable;
  logic anyEnableQ;
  logic regsClear;
  logic enRise;

  assign anyEnable = pins.serialEnablePin | (|pins.outputEnablePin);
  assign regsClear = !pins.supplyAbovePor | !anyEnable;
  assign enRise    = anyEnable & !anyEnableQ & pins.supplyAbovePor;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      anyEnableQ <= 1'b0;
    end else begin
      anyEnableQ <= anyEnable;
    end
  end

  // ----------------------------------------------------------------
  // Register strobes
  // ----------------------------------------------------------------
  logic       rdTop;
  logic       rdThm;
  logic       wrMskTop;
  logic       wrMskThm;
  logic       wrCfg;
  logic [7:0] mskTop;
  logic [7:0] mskThm;
  logic [7:0] cfg;

  // Read clears and writes ignored in shutdown, registers sit at defaults then
  assign rdTop    = regRd & !regsClear & (regAddr == ADDR_INT_TOP);
  assign rdThm    = regRd & !regsClear & (regAddr == ADDR_INT_THM);
  assign wrMskTop = regWr & !regsClear & (regAddr == ADDR_MSK_TOP);
  assign wrMskThm = regWr & !regsClear & (regAddr == ADDR_MSK_THM);
  assign wrCfg    = regWr & !regsClear & (regAddr == ADDR_CFG);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mskTop <= MSK_TOP_RST;
      mskThm <= MSK_THM_RST;
      cfg    <= CFG_RST;
    end else if (regsClear) begin
      mskTop <= MSK_TOP_RST;
      mskThm <= MSK_THM_RST;
      cfg    <= CFG_RST;
    end else begin
      if (wrMskTop) mskTop <= regWdata;
      if (wrMskThm) mskThm <= regWdata;
      if (wrCfg) cfg <= regWdata;
    end
  end
  mask_reset_a: assert property (regsClear |=>
    mskThm == MSK_THM_RST && !mskTop[UNDERVOLTAGE_LOCKOUT_INTERRUPT_BIT])
    else $error("masks not at defaults after register reset");

  // ----------------------------------------------------------------
  // Thermal monitor and shutdown
  // ----------------------------------------------------------------
  logic       hystHold;
  logic       monOn;
  logic       forceThermalMonitorEnable;
  logic [NCH-1:0] buckReq;

  assign forceThermalMonitorEnable = cfg[FORCE_THERMAL_MONITOR_ENABLE_BIT];
  assign buckReq = pins.outputEnablePin | cfg[CFG_BUCK_LSB +: NCH];
  assign monOn   = (|buckReq) | forceThermalMonitorEnable | hystHold;
  // Hysteresis keeps the monitor alive while the die cools
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hystHold <= 1'b0;
    end else if (monOn & pins.therm.above120) begin
      hystHold <= 1'b1;
    end else if (!pins.therm.above105) begin
      hystHold <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      thermalMonitorActive <= 1'b0;
      thermalShutdown      <= 1'b0;
      buckOn               <= '0;
    end else begin
      thermalMonitorActive <= monOn;
      thermalShutdown <= monOn & pins.therm.aboveShutdownThreshold;
      // No sequencing: all outputs drop on the same edge
      if ((monOn & pins.therm.aboveShutdownThreshold)
          | pins.undervoltage) begin
        buckOn <= '0;
      end else begin
        buckOn <= buckReq;
      end
    end
  end
  mon_force_a: assert property (forceThermalMonitorEnable |=>
    thermalMonitorActive)
    else $error("monitor off while forced on");
  hyst_hold_a: assert property (monOn && pins.therm.above120 ##1
    pins.therm.above105 |=> thermalMonitorActive)
    else $error("monitor released above the hysteresis level");
  shdn_off_a: assert property (monOn && pins.therm.aboveShutdownThreshold
    |=> buckOn == '0 && thermalShutdown)
    else $error("outputs not off on thermal shutdown");

  // ----------------------------------------------------------------
  // Edge-triggered interrupt capture
  // ----------------------------------------------------------------
  logic [THM_BITS-1:0] thmCond;
  logic [THM_BITS-1:0] thmCondQ;
  logic [THM_BITS-1:0] thmRise;
  logic [THM_BITS-1:0] intThm;
  logic                uvCondQ;
  logic                uvRise;
  logic                intTop;
  // Flags are only meaningful while the monitor is running
  assign thmCond[THM_W120_BIT] = monOn & pins.therm.above120;
  assign thmCond[THM_W140_BIT] = monOn & pins.therm.above140;
  assign thmCond[THM_SHUT_BIT] =
    monOn & pins.therm.aboveShutdownThreshold;
  assign thmRise = thmCond & ~thmCondQ;
  assign uvRise  = pins.undervoltage & !uvCondQ;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      thmCondQ <= '0;
      uvCondQ  <= 1'b0;
    end else begin
      thmCondQ <= thmCond;
      uvCondQ  <= pins.undervoltage;
    end
  end
  // Set wins over the read clear, so no event is lost
  for (genvar i = 0; i < THM_BITS; i++) begin : g_thm
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        intThm[i] <= 1'b0;
      end else if (regsClear) begin
        intThm[i] <= 1'b0;
      end else if (thmRise[i]) begin
        intThm[i] <= 1'b1;
      end else if (rdThm) begin
        intThm[i] <= 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      intTop <= 1'b0;
    end else if (regsClear) begin
      intTop <= 1'b0;
    end else if (uvRise) begin
      intTop <= 1'b1;
    end else if (rdTop) begin
      intTop <= 1'b0;
    end
  end
  rd_clear_a: assert property (rdThm && thmRise == '0 |=>
    intThm == '0)
    else $error("interrupt register not cleared by read");
  edge_only_a: assert property (intThm == '0 && thmRise == '0
    && !regsClear |=> intThm == '0)
    else $error("interrupt set without a condition edge");

  // ----------------------------------------------------------------
  // Interrupt request pin
  // ----------------------------------------------------------------
  logic pending;
  logic [7:0] srcSummary;

  assign pending =
    (intTop & !mskTop[UNDERVOLTAGE_LOCKOUT_INTERRUPT_BIT])
    | (|(intThm & ~mskThm[THM_BITS-1:0]));
  // Open drain: only ever drives low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      interruptRequestNOut <= 1'b0;
      interruptRequestNOe  <= 1'b0;
    end else begin
      interruptRequestNOut <= 1'b0;
      interruptRequestNOe  <= pending;
    end
  end
  irq_drive_a: assert property (pending |=> interruptRequestNOe)
    else $error("pin not pulled low on unmasked interrupt");
  irq_release_a: assert property (!pending |=> !interruptRequestNOe)
    else $error("pin held low with no pending bit");
  irq_hold_a: assert property (interruptRequestNOe && pending
    && !rdThm && !rdTop && !wrMskTop && !wrMskThm && !regsClear
    |=> pending ##1 interruptRequestNOe)
    else $error("pin released without read or mask");

  // Source indication follows its group, so a group read clears it
  assign srcSummary = {6'h00, |intThm, intTop};
  summary_a: assert property (rdThm && thmRise == '0 |=>
    !srcSummary[SRC_THM_BIT])
    else $error("source indication survived group read");

  // ----------------------------------------------------------------
  // Voltage defaults per output
  // ----------------------------------------------------------------
  sit_sel_t [NCH-1:0] outCfg;

  for (genvar c = 0; c < NCH; c++) begin : g_out
    logic wrVout;
    logic wrRf;
    assign wrVout = regWr & !regsClear
                    & (regAddr == ADDR_VOUT0 + 8'(c));
    assign wrRf   = regWr & !regsClear
                    & (regAddr == ADDR_RF0 + 8'(c));
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        outCfg[c] <= {VOUT_RST, FIELD2_RST, FIELD2_RST};
      end else if (regsClear) begin
        outCfg[c] <= {VOUT_RST, FIELD2_RST, FIELD2_RST};
      end else if (enRise) begin
        outCfg[c] <= selectionResistorDecode[c];
      end else begin
        if (wrVout) outCfg[c].outputVoltageTarget <= regWdata;
        if (wrRf) begin
          outCfg[c].outputVoltageRange <= regWdata[RF_RANGE_LSB +: 2];
          outCfg[c].switchingFrequencySelect <=
            regWdata[RF_FREQ_LSB +: 2];
        end
      end
    end
  end
  default_load_a: assert property (enRise && !regsClear |=>
    outCfg[0] == $past(selectionResistorDecode[0]))
    else $error("defaults not latched on enable rise");

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] next_regRdata;
  logic [7:0] rfIdx;
  logic [7:0] vIdx;

  assign vIdx  = regAddr - ADDR_VOUT0;
  assign rfIdx = regAddr - ADDR_RF0;
  always_comb begin
    next_regRdata = 8'h00;
    case (regAddr)
      ADDR_SRC:     next_regRdata = srcSummary;
      ADDR_INT_TOP: next_regRdata = {7'h00, intTop};
      ADDR_INT_THM: next_regRdata = {5'h00, intThm};
      ADDR_MSK_TOP: next_regRdata = mskTop;
      ADDR_MSK_THM: next_regRdata = mskThm;
      ADDR_CFG:     next_regRdata = cfg;
      ADDR_STAT:    next_regRdata = {4'h0, monOn, pins.therm.above140,
                                     pins.therm.above120, hystHold};
      default: begin
        if (vIdx < 8'(NCH)) begin
          next_regRdata = outCfg[vIdx[0]].outputVoltageTarget;
        end else if (rfIdx < 8'(NCH)) begin
          next_regRdata = {4'h0,
            outCfg[rfIdx[0]].switchingFrequencySelect,
            outCfg[rfIdx[0]].outputVoltageRange};
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      regRdata <= next_regRdata;
    end
  end

endmodule // sit_status_interrupt_thermal_ctrl
